//--- hw/dbu_top.sv
// debug breakpoint unit: breakpoint, status and control registers, alias
// routing, access detection and debug exception classification.
// assumes pipeline inputs are single-cycle pulses on core_clk; a raised
// exception is taken by the pipeline without back-pressure.
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - four 32-bit breakpoint addresses compared with every cycle's address.
// - with extensions off, alias registers reach control and status.
// - with extensions on, alias access raises undefined opcode instead.
// - enabled breakpoint match sets its hit flag in status.
// - matches of other breakpoints also flagged; disabled ones raise nothing.
// - detection on: debug register access flags and faults before access.
// - trap flag set: exception after each instruction, single-step flag.
// - task switch into trapping task sets task flag and raises exception.
// - local enables are per breakpoint and cleared on task switch.
// - global enables survive task switch; local or global arms a breakpoint.
// - compatibility bits stored but have no effect.
// - detect enable gates access fault and clears on any exception.
// - kind 00 fetch, 01 write, 10 I/O, 11 data read or write.
// - size 00 one byte, 01 two, 11 four; 10 undefined.
// - data, I/O, single-step and task traps raise 01h after instruction.
// - fetch breakpoints and access detection are faults raising 01h.
// - opcode CCh is a software breakpoint trapping with 03h.
module dbu_top (
	input  wire logic             core_clk,
	input  wire logic             sys_rst,
	input  wire logic             ext_dbg_switch,
	input  wire logic             trap_flag,
	input  wire logic             dr_req,
	input  wire logic             dr_write,
	input  wire logic [2:0]       dr_index,
	input  wire logic [31:0]      dr_wdata,
	output var  logic             dr_ack,
	output var  logic             dr_ud,
	output var  logic [31:0]      dr_rdata,
	input  wire logic             cyc_valid,
	input  wire logic [31:0]      cyc_addr,
	input  wire logic [1:0]       cyc_last,
	input  wire dbu_pkg::dbu_cyc_t cyc_type,
	input  wire logic             retire_valid,
	input  wire logic [7:0]       retire_opcode,
	input  wire logic             task_switch,
	input  wire logic             task_trap,
	output var  logic             exc_valid,
	output var  logic             exc_fault,
	output var  logic [7:0]       exc_vector
);
	import dbu_pkg::*;

	logic [31:0] bp_addr [4];
	logic [31:0] status;
	logic [31:0] control;
	logic        data_pend;

	dbu_cmp_if cmp ();

	assign cmp.cyc_addr = cyc_addr;
	assign cmp.cyc_last = cyc_last;
	assign cmp.cyc_type = cyc_type;
	assign cmp.bp       = bp_addr;
	assign cmp.control  = control;

	dbu_match u_match (
		.m (cmp.cmp)
	);

	// register port decode
	wire       alias_sel;
	wire       detect_now;
	wire       ud_now;
	wire       do_access;
	wire [2:0] eff_index;
	wire       wr_status;
	wire       wr_control;

	assign alias_sel  = (dr_index == IDX_ALIAS_ST) ||
		(dr_index == IDX_ALIAS_CT);
	// the check precedes the access, so a detected access never lands
	assign detect_now = dr_req && control[CT_GD];
	assign ud_now     = dr_req && !detect_now && alias_sel &&
		ext_dbg_switch;
	assign do_access  = dr_req && !detect_now && !ud_now;
	// alias index 4/5 folds onto 6/7 by forcing bit 1
	assign eff_index  = alias_sel ? {2'b11, dr_index[0]} :
		dr_index;
	assign wr_status  = do_access && dr_write && (eff_index == IDX_STATUS);
	assign wr_control = do_access && dr_write &&
		(eff_index == IDX_CONTROL);

	wire [31:0] rd_mux;
	assign rd_mux = (eff_index == IDX_STATUS)  ? status :
		(eff_index == IDX_CONTROL) ? control :
		bp_addr[eff_index[1:0]];

	// breakpoint enables and kinds
	wire [3:0] bp_en;
	wire [3:0] bp_exec;

	genvar i;
	generate
		for (i = 0; i < 4; i++) begin : g_en
			// global bit alone suffices; compat bits 8/9 feed nothing
			assign bp_en[i] = control[2 * i] ||
				control[2 * i + 1];
			assign bp_exec[i] = control[CT_FIELD_LSB + CT_FIELD_W * i +: 2]
				== KIND_EXEC;
		end
	endgenerate

	wire any_en_hit;
	wire fetch_fault;
	wire data_hit;

	assign any_en_hit  = cyc_valid && |(cmp.match & bp_en);
	assign fetch_fault = cyc_valid &&
		|(cmp.match & bp_en & bp_exec);
	assign data_hit    = cyc_valid &&
		|(cmp.match & bp_en & ~bp_exec);

	// exception sources, highest priority first
	wire fault_now;
	wire ss_now;
	wire ts_now;
	wire trap01_now;
	wire trap03_now;
	wire exc_now;

	assign fault_now  = fetch_fault || detect_now;
	assign ss_now     = retire_valid && trap_flag;
	assign ts_now     = task_switch && task_trap;
	// a data hit in the retire cycle belongs to the retiring instruction
	assign trap01_now = (retire_valid && (data_pend || data_hit)) ||
		ss_now || ts_now;
	assign trap03_now = retire_valid &&
		(retire_opcode == OPC_INT3);
	assign exc_now    = fault_now || trap01_now || trap03_now;

	// status: hardware sets win over a software write in the same cycle
	logic [31:0] next_status;
	always_comb begin
		next_status = wr_status ? (dr_wdata & ST_MASK) : status;
		if (any_en_hit) begin
			// every matching breakpoint, enabled or not, is flagged
			next_status[ST_HIT_LSB +: 4] = next_status[ST_HIT_LSB +: 4] |
				cmp.match;
		end
		if (detect_now) begin
			next_status[ST_BD] = 1'b1;
		end
		if (ss_now) begin
			next_status[ST_BS] = 1'b1;
		end
		if (ts_now) begin
			next_status[ST_BT] = 1'b1;
		end
	end

	logic [31:0] next_control;
	always_comb begin
		next_control = wr_control ? (dr_wdata & CT_MASK) : control;
		if (task_switch) begin
			next_control = next_control & ~CT_LOCALS;
		end
		if (exc_now) begin
			next_control[CT_GD] = 1'b0;
		end
	end

	wire next_pend;
	// limitation: a trap lost to a same-cycle fault is not replayed
	assign next_pend = !retire_valid && (data_pend || data_hit);

	wire [7:0] next_vector;
	assign next_vector = (fault_now || trap01_now) ? VEC_DEBUG : VEC_BREAK;

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			status    <= ST_RST;
			control   <= CT_RST;
			data_pend <= 1'b0;
		end else begin
			status    <= next_status;
			control   <= next_control;
			data_pend <= next_pend;
		end
	end

	always_ff @(posedge core_clk) begin
		for (int k = 0; k < 4; k++) begin
			if (sys_rst) begin
				bp_addr[k] <= BP_RST;
			end else if (do_access && dr_write &&
				eff_index == 3'(k)) begin
				bp_addr[k] <= dr_wdata;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			dr_ack     <= 1'b0;
			dr_ud      <= 1'b0;
			dr_rdata   <= 32'h00000000;
			exc_valid  <= 1'b0;
			exc_fault  <= 1'b0;
			exc_vector <= 8'h00;
		end else begin
			dr_ack     <= do_access;
			dr_ud      <= ud_now;
			dr_rdata   <= (do_access && !dr_write) ? rd_mux : 32'h00000000;
			exc_valid  <= exc_now;
			exc_fault  <= fault_now;
			exc_vector <= exc_now ? next_vector : 8'h00;
		end
	end

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (sys_rst);

	bp_write_a: assert property (
		do_access && dr_write && dr_index == IDX_BP2
		|=> bp_addr[2] == $past(dr_wdata))
		else $error("breakpoint address not written");

	alias_route_a: assert property (
		dr_req && !control[CT_GD] && !ext_dbg_switch &&
		dr_index == IDX_ALIAS_CT && !dr_write
		|=> dr_ack && !dr_ud && dr_rdata == $past(control))
		else $error("alias control read not routed");

	alias_ud_a: assert property (
		dr_req && !control[CT_GD] && ext_dbg_switch && alias_sel
		|=> dr_ud && !dr_ack && !exc_valid)
		else $error("alias access did not raise undefined opcode");

	hit_flag_a: assert property (
		any_en_hit
		|=> (status[3:0] & $past(cmp.match)) == $past(cmp.match))
		else $error("hit flags not set for matching breakpoints");

	disabled_quiet_a: assert property (
		cyc_valid && bp_en == 4'h0 && !dr_req && !retire_valid &&
		!task_switch
		|=> !exc_valid)
		else $error("exception raised for a disabled breakpoint");

	access_fault_a: assert property (
		dr_req && control[CT_GD]
		|=> exc_valid && exc_fault && exc_vector == VEC_DEBUG &&
		status[ST_BD] && !control[CT_GD] && !dr_ack)
		else $error("debug register access not trapped");

	single_step_a: assert property (
		ss_now && !fault_now
		|=> exc_valid && !exc_fault && exc_vector == VEC_DEBUG &&
		status[ST_BS])
		else $error("single step exception missing");

	task_switch_a: assert property (
		ts_now
		|=> status[ST_BT] && (control & CT_LOCALS) == 32'h00000000)
		else $error("task switch trap or local clear missing");

	data_trap_a: assert property (
		data_hit && !retire_valid && !fault_now
		##1 (retire_valid && !fault_now)
		|=> exc_valid && !exc_fault && exc_vector == VEC_DEBUG)
		else $error("data breakpoint trap not raised at retire");

	fetch_fault_a: assert property (
		fetch_fault
		|=> exc_valid && exc_fault && exc_vector == VEC_DEBUG)
		else $error("instruction breakpoint fault missing");

	int3_trap_a: assert property (
		trap03_now && !trap01_now && !fault_now
		|=> exc_valid && !exc_fault && exc_vector == VEC_BREAK)
		else $error("software breakpoint vector wrong");

	cover_fetch_c: cover property (fetch_fault ##1 exc_valid);
	cover_data_c: cover property (data_hit ##[1:20] retire_valid);
	cover_ud_c: cover property (ud_now ##1 dr_ud);
	cover_int3_c: cover property (trap03_now && !trap01_now);

endmodule
`default_nettype wire

//--- common/dbu_pkg.sv
// debug breakpoint unit: register indices, field positions, reset values,
// encodings and vectors shared by the unit and its comparator.
// assumes the pipeline presents one processor cycle per clock at most.
package dbu_pkg;

	// register indices as carried by the move-to/from-debug-register port
	localparam logic [2:0] IDX_BP0      = 3'h0;
	localparam logic [2:0] IDX_BP1      = 3'h1;
	localparam logic [2:0] IDX_BP2      = 3'h2;
	localparam logic [2:0] IDX_BP3      = 3'h3;
	localparam logic [2:0] IDX_ALIAS_ST = 3'h4;
	localparam logic [2:0] IDX_ALIAS_CT = 3'h5;
	localparam logic [2:0] IDX_STATUS   = 3'h6;
	localparam logic [2:0] IDX_CONTROL  = 3'h7;

	// debug_status fields
	localparam int ST_HIT_LSB = 0;
	localparam int ST_BD      = 13;
	localparam int ST_BS      = 14;
	localparam int ST_BT      = 15;
	localparam logic [31:0] ST_MASK = 32'h0000E00F;
	localparam logic [31:0] ST_RST  = 32'h00000000;

	// debug_control fields: local enable at 2i, global enable at 2i+1
	localparam int CT_LE        = 8;
	localparam int CT_GE        = 9;
	localparam int CT_GD        = 13;
	localparam int CT_FIELD_LSB = 16;
	localparam int CT_FIELD_W   = 4;
	localparam logic [31:0] CT_MASK   = 32'hFFFF23FF;
	localparam logic [31:0] CT_LOCALS = 32'h00000055;
	localparam logic [31:0] CT_RST    = 32'h00000000;

	localparam logic [31:0] BP_RST = 32'h00000000;

	localparam logic [7:0] VEC_DEBUG = 8'h01;
	localparam logic [7:0] VEC_BREAK = 8'h03;
	localparam logic [7:0] OPC_INT3  = 8'hCC;

	// breakpoint kind field encoding
	typedef enum logic [1:0] {
		KIND_EXEC  = 2'h0,
		KIND_WRITE = 2'h1,
		KIND_IO    = 2'h2,
		KIND_DATA  = 2'h3
	} dbu_kind_t;

	// type of the processor cycle being checked
	typedef enum logic [1:0] {
		CYC_FETCH = 2'h0,
		CYC_READ  = 2'h1,
		CYC_WRITE = 2'h2,
		CYC_IO    = 2'h3
	} dbu_cyc_t;

endpackage

//--- common/dbu_cmp_if.sv
// debug breakpoint unit: carrier between the unit and its comparator.
// assumes both ends sit in the core_clk domain; all signals combinational.
`timescale 1ns/1ns
`default_nettype none
interface dbu_cmp_if;
	import dbu_pkg::*;
	logic [31:0] cyc_addr;
	logic [1:0]  cyc_last;
	dbu_cyc_t    cyc_type;
	logic [31:0] bp [4];
	logic [31:0] control;
	logic [3:0]  match;

	modport core (output cyc_addr, cyc_last, cyc_type, bp, control,
		input match);
	modport cmp (input cyc_addr, cyc_last, cyc_type, bp, control,
		output match);
endinterface
`default_nettype wire

//--- hw/dbu_match.sv
// debug breakpoint unit: address and cycle-type comparator for the four
// breakpoints. assumes cyc_last is the byte count of the cycle minus one.
`timescale 1ns/1ns
`default_nettype none
module dbu_match (
	dbu_cmp_if.cmp m
);
	import dbu_pkg::*;

	// byte ranges overlap; 33 bits so a range ending at 4 GB cannot wrap
	function automatic logic ranges_meet(
		input logic [31:0] a_start,
		input logic [1:0]  a_last,
		input logic [31:0] b_start,
		input logic [1:0]  b_last
	);
		logic [32:0] a_end;
		logic [32:0] b_end;
		a_end = {1'b0, a_start} + {31'h0, a_last};
		b_end = {1'b0, b_start} + {31'h0, b_last};
		ranges_meet = ({1'b0, a_start} <= b_end) &&
			({1'b0, b_start} <= a_end);
	endfunction

	function automatic logic kind_fits(
		input dbu_kind_t kind,
		input dbu_cyc_t  cyc
	);
		case (kind)
			KIND_EXEC:  kind_fits = (cyc == CYC_FETCH);
			KIND_WRITE: kind_fits = (cyc == CYC_WRITE);
			KIND_IO:    kind_fits = (cyc == CYC_IO);
			KIND_DATA:  kind_fits = (cyc == CYC_READ) ||
				(cyc == CYC_WRITE);
			default:    kind_fits = 1'b0;
		endcase
	endfunction

	wire [3:0] hit_w;

	genvar i;
	generate
		for (i = 0; i < 4; i++) begin : g_bp
			wire [1:0] kind_w;
			wire [1:0] size_w;
			assign kind_w = m.control[CT_FIELD_LSB + CT_FIELD_W * i +: 2];
			assign size_w = m.control[CT_FIELD_LSB + CT_FIELD_W * i + 2 +: 2];
			// size 00/01/11 covers 1/2/4 bytes; 10 is undefined, reads as 3
			assign hit_w[i] = kind_fits(dbu_kind_t'(kind_w),
				m.cyc_type) && ranges_meet(m.bp[i], size_w,
				m.cyc_addr, m.cyc_last);
		end
	endgenerate

	assign m.match = hit_w;

endmodule
`default_nettype wire

//--- testbench/dbu_pipe_model.sv
// debug breakpoint unit bench: pipeline model issuing cycles, retires and
// task switches. assumes callers resume just after a clock edge.
`timescale 1ns/1ns
`default_nettype none
module dbu_pipe_model (
	input  wire logic              core_clk,
	output var  logic              cyc_valid,
	output var  logic [31:0]       cyc_addr,
	output var  logic [1:0]        cyc_last,
	output var  dbu_pkg::dbu_cyc_t cyc_type,
	output var  logic              retire_valid,
	output var  logic [7:0]        retire_opcode,
	output var  logic              task_switch,
	output var  logic              task_trap
);
	import dbu_pkg::*;
	initial begin
		cyc_valid = 1'b0;
		cyc_addr = 32'h0;
		cyc_last = 2'h0;
		cyc_type = CYC_FETCH;
		retire_valid = 1'b0;
		retire_opcode = 8'h0;
		task_switch = 1'b0;
		task_trap = 1'b0;
	end
	// released qualifiers go inverted so stale values cannot match
	task automatic cyc(input logic [31:0] a, input logic [1:0] l,
		input dbu_cyc_t t);
		@(posedge core_clk);
		cyc_valid <= 1'b1;
		cyc_addr  <= a;
		cyc_last  <= l;
		cyc_type  <= t;
		@(posedge core_clk);
		cyc_valid <= 1'b0;
		cyc_addr  <= ~a;
		cyc_last  <= ~l;
		cyc_type  <= dbu_cyc_t'(~t);
		#1;
	endtask
	task automatic ret(input logic [7:0] op);
		@(posedge core_clk);
		retire_valid  <= 1'b1;
		retire_opcode <= op;
		@(posedge core_clk);
		retire_valid  <= 1'b0;
		retire_opcode <= ~op;
		#1;
	endtask
	task automatic tsw(input logic tt);
		@(posedge core_clk);
		task_switch <= 1'b1;
		task_trap   <= tt;
		@(posedge core_clk);
		task_switch <= 1'b0;
		task_trap   <= ~tt;
		#1;
	endtask
endmodule
`default_nettype wire

//--- testbench/test_debug_breakpoint_unit.sv
// debug breakpoint unit bench: register table loop, then exceptions.
// assumes answers land at the taking edge and are read 1ns later.
`timescale 1ns/1ns
`default_nettype none
module test_debug_breakpoint_unit;
	import dbu_pkg::*;
	typedef struct packed {
		logic [2:0]  wi;
		logic [31:0] wd;
		logic [2:0]  ri;
		logic [31:0] ex;
	} dbu_row_t;
	logic              core_clk, sys_rst, ext_dbg_switch, trap_flag;
	logic              dr_req, dr_write, dr_ack, dr_ud;
	logic [2:0]        dr_index;
	logic [31:0]       dr_wdata, dr_rdata, rd;
	logic              cyc_valid, retire_valid, task_switch, task_trap;
	logic [31:0]       cyc_addr;
	logic [1:0]        cyc_last;
	dbu_cyc_t          cyc_type;
	logic [7:0]        retire_opcode, exc_vector;
	logic              exc_valid, exc_fault;
	int                miscompares = 0;
	int                cmp_count = 0;
	dbu_row_t rows [8] = '{
		'{3'h0, 32'hA5A55A5A, 3'h0, 32'hA5A55A5A},
		'{3'h1, 32'h12345678, 3'h1, 32'h12345678},
		'{3'h2, 32'hFFFFFFFF, 3'h2, 32'hFFFFFFFF},
		'{3'h3, 32'hDEADBEEF, 3'h3, 32'hDEADBEEF},
		'{3'h7, 32'hFFFFDFFF, 3'h5, 32'hFFFF03FF},
		'{3'h6, 32'hFFFFFFFF, 3'h4, 32'h0000E00F},
		'{3'h5, 32'h00000000, 3'h7, 32'h00000000},
		'{3'h4, 32'h00000000, 3'h6, 32'h00000000}
	};
	dbu_top dut_u (.core_clk(core_clk), .sys_rst(sys_rst),
		.ext_dbg_switch(ext_dbg_switch), .trap_flag(trap_flag),
		.dr_req(dr_req), .dr_write(dr_write), .dr_index(dr_index),
		.dr_wdata(dr_wdata), .dr_ack(dr_ack), .dr_ud(dr_ud),
		.dr_rdata(dr_rdata), .cyc_valid(cyc_valid), .cyc_addr(cyc_addr),
		.cyc_last(cyc_last), .cyc_type(cyc_type),
		.retire_valid(retire_valid), .retire_opcode(retire_opcode),
		.task_switch(task_switch), .task_trap(task_trap),
		.exc_valid(exc_valid), .exc_fault(exc_fault),
		.exc_vector(exc_vector));
	dbu_pipe_model pipe_u (.core_clk(core_clk), .cyc_valid(cyc_valid),
		.cyc_addr(cyc_addr), .cyc_last(cyc_last), .cyc_type(cyc_type),
		.retire_valid(retire_valid), .retire_opcode(retire_opcode),
		.task_switch(task_switch), .task_trap(task_trap));
	always #4 core_clk = ~core_clk;
	// packs ud, ack, valid, fault, vector for one compare
	function automatic logic [31:0] resp();
		return {20'h0, dr_ud, dr_ack, exc_valid, exc_fault, exc_vector};
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: %h vs %h", $time, seen, exp);
		end
	endtask
	task automatic test_done();
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic acc(input logic w, input logic [2:0] i,
		input logic [31:0] d);
		@(posedge core_clk);
		dr_req   <= 1'b1;
		dr_write <= w;
		dr_index <= i;
		dr_wdata <= d;
		@(posedge core_clk);
		dr_req   <= 1'b0;
		dr_wdata <= ~d;
		#1;
		rd = dr_rdata;
	endtask
	task automatic wr(input logic [2:0] i, input logic [31:0] d);
		acc(1'b1, i, d);
		chk(resp(), 32'h400);
	endtask
	task automatic rchk(input logic [2:0] i, input logic [31:0] e);
		acc(1'b0, i, 32'h0);
		chk(resp(), 32'h400);
		chk(rd, e);
	endtask
	initial begin
		core_clk = 1'b0;
		sys_rst = 1'b1;
		ext_dbg_switch = 1'b0;
		trap_flag = 1'b0;
		dr_req = 1'b0;
		dr_write = 1'b0;
		dr_index = 3'h0;
		repeat (3) @(posedge core_clk);
		sys_rst <= 1'b0;
		foreach (rows[n]) begin
			wr(rows[n].wi, rows[n].wd);
			rchk(rows[n].ri, rows[n].ex);
		end
		// mid-run reset must clear breakpoint 2 again
		@(posedge core_clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		sys_rst <= 1'b0;
		rchk(IDX_BP2, 32'h0);
		wr(IDX_BP0, 32'h1000);
		wr(IDX_BP1, 32'h1000);
		wr(IDX_CONTROL, 32'h1);
		pipe_u.cyc(32'h1000, 2'h0, CYC_FETCH);
		chk(resp(), 32'h301);
		rchk(IDX_STATUS, 32'h3);
		wr(IDX_STATUS, 32'h0);
		// same matching fetch with every enable off: silent, no flags
		wr(IDX_CONTROL, 32'h0);
		pipe_u.cyc(32'h1000, 2'h0, CYC_FETCH);
		chk(resp(), 32'h0);
		rchk(IDX_STATUS, 32'h0);
		wr(IDX_BP2, 32'h2000);
		wr(IDX_CONTROL, 32'h0D000021);
		pipe_u.cyc(32'h2003, 2'h0, CYC_WRITE);
		chk(resp(), 32'h0);
		pipe_u.ret(8'h90);
		chk(resp(), 32'h201);
		pipe_u.cyc(32'h2000, 2'h0, CYC_READ);
		pipe_u.ret(8'h90);
		chk(resp(), 32'h0);
		rchk(IDX_STATUS, 32'h4);
		pipe_u.tsw(1'b0);
		chk(resp(), 32'h0);
		rchk(IDX_CONTROL, 32'h0D000020);
		pipe_u.tsw(1'b1);
		chk(resp(), 32'h201);
		rchk(IDX_STATUS, 32'h8004);
		@(posedge core_clk);
		trap_flag <= 1'b1;
		pipe_u.ret(8'h90);
		chk(resp(), 32'h201);
		trap_flag <= 1'b0;
		rchk(IDX_STATUS, 32'hC004);
		pipe_u.ret(OPC_INT3);
		chk(resp(), 32'h203);
		wr(IDX_CONTROL, 32'h2000);
		acc(1'b0, IDX_BP0, 32'h0);
		chk(resp(), 32'h301);
		rchk(IDX_CONTROL, 32'h0);
		rchk(IDX_STATUS, 32'hE004);
		@(posedge core_clk);
		ext_dbg_switch <= 1'b1;
		acc(1'b0, IDX_ALIAS_ST, 32'h0);
		chk(resp(), 32'h800);
		acc(1'b1, IDX_ALIAS_CT, 32'hFF);
		chk(resp(), 32'h800);
		wr(IDX_BP3, 32'h60);
		wr(IDX_CONTROL, 32'h20000080);
		pipe_u.cyc(32'h5F, 2'h1, CYC_IO);
		pipe_u.ret(8'h90);
		chk(resp(), 32'h201);
		// hit one cycle before the retire that owns it
		fork
			pipe_u.cyc(32'h60, 2'h0, CYC_IO);
			begin
				@(posedge core_clk);
				pipe_u.ret(8'h90);
			end
		join
		chk(resp(), 32'h201);
		test_done();
	end
endmodule
`default_nettype wire
